// file: eewp_pkg.sv
// Shared constants, codes and carrier types for the EEPROM write-protect block
package eewp_pkg;

	// Instruction codes, most significant bit first on the serial input
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
	localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_LATCH_SET    = 8'h06;

	// Serial clock counts within one frame
	localparam int         CNT_W          = 12;
	localparam logic [11:0] CNT_ONE       = 12'h001;
	localparam logic [11:0] CNT_MAX       = 12'hfff;
	localparam logic [11:0] CNT_OPCODE    = 12'h008;
	localparam logic [11:0] CNT_BYTE1     = 12'h010;
	localparam logic [11:0] CNT_BYTE2     = 12'h018;
	localparam logic [11:0] CNT_FIRST_DAT = 12'h020;
	localparam logic [2:0]  BYTE_ALIGN    = 3'h0;
	localparam logic [2:0]  BIT_TOP       = 3'h7;

	// Status byte bit positions
	localparam int ST_WIP    = 0;
	localparam int ST_LATCH  = 1;
	localparam int ST_BP_LO  = 2;
	localparam int ST_BP_HI  = 3;
	localparam int ST_HW_EN  = 7;

	// Array guard ranges, 14-bit array address
	localparam int          ADDR_W       = 14;
	localparam logic [13:0] QUARTER_BASE = 14'h3000;
	localparam logic [13:0] HALF_BASE    = 14'h2000;
	localparam logic [1:0]  BP_NONE      = 2'b00;
	localparam logic [1:0]  BP_QUARTER   = 2'b01;
	localparam logic [1:0]  BP_HALF      = 2'b10;
	localparam logic [1:0]  BP_ALL       = 2'b11;

	// Internal write cycle duration
	localparam int CLK_FREQ_MHZ     = 40;
	localparam int WRITE_TIME_US    = 5000;
	localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;
	localparam int BUSY_W           = 20;

	typedef struct packed {
		logic hwProtectEnable;
		logic blockProtectHi;
		logic blockProtectLo;
	} eewp_nv_s;

	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  byte1;
		logic [7:0]  byte2;
		logic [11:0] bitCount;
	} eewp_frame_s;

	typedef struct packed {
		logic        start;
		logic        toStatus;
		logic [13:0] addr;
	} eewp_wreq_s;

	typedef enum logic [1:0] {
		FR_BLOCKED = 2'b00,
		FR_STANDBY = 2'b01,
		FR_ACTIVE  = 2'b10
	} eewp_frame_e;

endpackage

// file: eewp_sync.sv
// Two-flop level synchroniser, one per bit
module eewp_sync
	import eewp_pkg::*;
#(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
)
(
	// Destination clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] stage1;

	// The first stage feeds only the second
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1 <= RST;
			dout   <= RST;
		end
		else
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// file: eewp_link.sv
// Serial link front end on the serial clock: bit capture and status shift-out
module eewp_link
	import eewp_pkg::*;
(
	// Link clock and resets
	input  wire logic   spiClk,
	input  wire logic   nrst,
	input  wire logic   csN,
	// Serial pins
	input  wire logic   serialIn,
	output logic        serialOut,
	output logic        serialOutOe,
	// Status already synchronised to this clock
	input  wire logic [7:0] statusLink,
	// Captured frame, stable once the clock stops
	output eewp_frame_s frame
);

	logic        started;
	logic [7:0]  shiftIn;
	logic [7:0]  nextByte;
	logic [11:0] nextCount;
	logic        frameRstN;

	// Deselect clears the start flag and output drive at once, since the clock may never tick again; the captured frame is kept
	assign frameRstN = nrst & ~csN;

	always_ff @(posedge spiClk or negedge frameRstN)
	begin
		if (!frameRstN)
			started <= 1'b0;
		else
			started <= 1'b1;
	end

	always_comb
	begin
		nextByte  = started ? {shiftIn[6:0], serialIn} : {7'h00, serialIn};
		nextCount = CNT_ONE;
		if (started)
			nextCount = (frame.bitCount == CNT_MAX) ? CNT_MAX : frame.bitCount + CNT_ONE;
	end

	always_ff @(posedge spiClk or negedge nrst)
	begin
		if (!nrst)
		begin
			shiftIn <= 8'h00;
			frame   <= '0;
		end
		else
		begin
			shiftIn        <= nextByte;
			frame.bitCount <= nextCount;
			if (nextCount == CNT_OPCODE)
				frame.opcode <= nextByte;
			if (nextCount == CNT_BYTE1)
				frame.byte1 <= nextByte;
			if (nextCount == CNT_BYTE2)
				frame.byte2 <= nextByte;
		end
	end

	// Output changes on the falling edge so the host samples a settled bit
	always_ff @(negedge spiClk or negedge frameRstN)
	begin
		if (!frameRstN)
		begin
			serialOut   <= 1'b0;
			serialOutOe <= 1'b0;
		end
		else if (started && frame.bitCount >= CNT_OPCODE && frame.opcode == OP_STATUS_READ)
		begin
			serialOutOe <= 1'b1;
			serialOut   <= statusLink[BIT_TOP - frame.bitCount[2:0]];
		end
	end

endmodule

// file: eewp_write_protect.sv
// Write-protect, status-write and write-cycle control of the serial EEPROM
//
// How it works
// - Status-write changes only the protect-enable and two block-protect bits.
// - Block-protect codes guard none, top quarter, top half or whole array.
// - Hardware protection is active only with pin low and enable bit set.
// - Pin high or enable bit clear means hardware protection is off.
// - Hardware protection blocks status writes only, never unguarded array writes.
// - Latch clear blocks all; guarded blocks never; status needs no hardware protect.
// - Power-up clears the write latch.
// - Completed byte, page or status write clears the write latch.
// - Write cycle starts only on a deselect at a whole-byte clock count: exactly 16 for status, 32 or more for array.
// - During a write cycle only status reads are served, other accesses are ignored; programming runs on.
// - Power-up state is standby, deselected, latch cleared.
// - Serial output floats except while shifting out read data.
// - Leaving standby needs a falling chip select seen after power-up.
// - Protect-enable and block-protect bits are nonvolatile across power cycles.
// - Latch-set takes effect only after eight bits then chip select rising.
// - Input sampled on rising clock, most significant bit first.
// - Write-in-progress reads one during a write cycle, read-only.
module eewp_write_protect
	import eewp_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// Serial link pins
	input  wire logic spiClk,
	input  wire logic csN,
	input  wire logic serialIn,
	output logic      serialOut,
	output logic      serialOutOe,
	// Hardware protect pin
	input  wire logic wpN,
	// Nonvolatile cell image
	input  eewp_nv_s  nvRestore,
	output eewp_nv_s  nvStore,
	// Status and write requests
	output logic [7:0] statusByte,
	output eewp_wreq_s writeReq,
	output logic       hwProtectActive,
	output logic       standby
);

	localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(WRITE_CYCLES);
	localparam logic [BUSY_W-1:0] BUSY_ONE  = {{(BUSY_W-1){1'b0}}, 1'b1};
	localparam logic [BUSY_W-1:0] BUSY_ZERO = '0;
	localparam logic [1:0]        PIN_RST   = 2'b00;
	localparam logic [7:0]        STAT_RST  = 8'h00;

	// Array guard for a block-protect code
	function automatic logic isGuarded(input logic [1:0] bp, input logic [13:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (bp)
			BP_NONE:    hit = 1'b0;
			BP_QUARTER: hit = (addr >= QUARTER_BASE);
			BP_HALF:    hit = (addr >= HALF_BASE);
			BP_ALL:     hit = 1'b1;
		endcase
		return hit;
	endfunction

	// Status byte image; unused bits read as zero
	function automatic logic [7:0] makeStatus(input eewp_nv_s nv, input logic latch, input logic busy);
		logic [7:0] s;
		s           = 8'h00;
		s[ST_HW_EN] = nv.hwProtectEnable;
		s[ST_BP_HI] = nv.blockProtectHi;
		s[ST_BP_LO] = nv.blockProtectLo;
		s[ST_LATCH] = latch;
		s[ST_WIP]   = busy;
		return s;
	endfunction

	// Exact bit count of a frame
	function automatic logic countIs(input logic [11:0] cnt, input logic [11:0] want);
		logic hit;
		hit = (cnt == want);
		return hit;
	endfunction

	// Whole bytes of at least the given length; a saturated count never qualifies
	function automatic logic byteFramed(input logic [11:0] cnt, input logic [11:0] least);
		logic ok;
		ok = (cnt >= least)
			&& (cnt[2:0] == BYTE_ALIGN)
			&& (cnt != CNT_MAX);
		return ok;
	endfunction

	logic [1:0]        pinSync;
	logic              csHigh;
	logic              wpHigh;
	logic              csPrev;
	logic              csRise;
	logic              csFall;
	eewp_frame_e       frameState;
	eewp_frame_e       next_frameState;
	logic              frameDone;
	eewp_frame_s       frame;
	logic [7:0]        statusLink;
	logic              nvLoaded;
	eewp_nv_s          nvBits;
	logic              writeLatch;
	logic              writeInProgress;
	logic [BUSY_W-1:0] busyCount;
	logic              busyEnd;
	logic              cmdLatchSet;
	logic              cmdLatchClr;
	logic              cmdStatusWr;
	logic              cmdArrayWr;
	logic              arrayAligned;
	logic              addrGuarded;
	logic              startWrite;
	logic [13:0]       frameAddr;
	logic              latchFramed;
	logic              statusFramed;
	logic              statusAllowed;
	logic              arrayAllowed;

	// Pins into the reference clock domain
	eewp_sync #(
		.W   (2),
		.RST (PIN_RST)
	) u_pinSync (
		.clk  (ref_clk),
		.nrst (nrst),
		.din  ({wpN, csN}),
		.dout (pinSync)
	);

	assign csHigh = pinSync[0];
	assign wpHigh = pinSync[1];

	// Status into the link clock domain; each bit changes rarely and alone matters
	eewp_sync #(
		.W   (8),
		.RST (STAT_RST)
	) u_statSync (
		.clk  (spiClk),
		.nrst (nrst),
		.din  (statusByte),
		.dout (statusLink)
	);

	// Link-side capture and status shift-out
	eewp_link u_link (
		.spiClk      (spiClk),
		.nrst        (nrst),
		.csN         (csN),
		.serialIn    (serialIn),
		.serialOut   (serialOut),
		.serialOutOe (serialOutOe),
		.statusLink  (statusLink),
		.frame       (frame)
	);

	// Chip select edges; synchroniser reset low so a select held at power-up is not an edge
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			csPrev <= 1'b0;
		else
			csPrev <= csHigh;
	end

	assign csRise = csHigh & ~csPrev;
	assign csFall = ~csHigh & csPrev;

	// Frame tracking
	always_comb
	begin
		next_frameState = frameState;
		unique case (frameState)
			FR_BLOCKED:
			begin
				if (csHigh)
					next_frameState = FR_STANDBY;
			end
			FR_STANDBY:
			begin
				if (csFall)
					next_frameState = FR_ACTIVE;
			end
			FR_ACTIVE:
			begin
				if (csRise)
					next_frameState = FR_STANDBY;
			end
			default:
				next_frameState = FR_BLOCKED;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			frameState <= FR_BLOCKED;
		else
			frameState <= next_frameState;
	end

	// Frame fields are stable here: the serial clock has stopped before the deselect
	assign frameDone = (frameState == FR_ACTIVE) && csRise;
	assign standby   = (frameState != FR_ACTIVE);

	// Hardware protection
	assign hwProtectActive = nvBits.hwProtectEnable & ~wpHigh;

	// Instruction decode at deselect
	assign frameAddr    = {frame.byte1[5:0], frame.byte2};
	assign arrayAligned = byteFramed(frame.bitCount, CNT_FIRST_DAT);
	assign latchFramed  = countIs(frame.bitCount, CNT_OPCODE);
	assign statusFramed = countIs(frame.bitCount, CNT_BYTE1);
	assign addrGuarded  = isGuarded({nvBits.blockProtectHi, nvBits.blockProtectLo}, frameAddr);

	// Protection matrix: the latch gates everything, hardware protect only the status bits
	assign statusAllowed = writeLatch && !hwProtectActive;
	assign arrayAllowed  = writeLatch && !addrGuarded;

	always_comb
	begin
		cmdLatchSet = 1'b0;
		cmdLatchClr = 1'b0;
		cmdStatusWr = 1'b0;
		cmdArrayWr  = 1'b0;
		if (frameDone && !writeInProgress)
		begin
			unique case (frame.opcode)
				OP_LATCH_SET:
				begin
					cmdLatchSet = latchFramed;
				end
				OP_LATCH_CLEAR:
				begin
					cmdLatchClr = latchFramed;
				end
				OP_STATUS_WRITE:
				begin
					cmdStatusWr = statusFramed && statusAllowed;
				end
				OP_ARRAY_WRITE:
				begin
					cmdArrayWr = arrayAligned && arrayAllowed;
				end
				default:
				begin
					cmdLatchSet = 1'b0;
				end
			endcase
		end
	end

	assign startWrite = cmdStatusWr | cmdArrayWr;

	// Nonvolatile bits: the cell image is picked up just after reset release
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			nvLoaded <= 1'b0;
		else
			nvLoaded <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			nvBits <= '0;
		else if (!nvLoaded)
			nvBits <= nvRestore;
		else if (cmdStatusWr)
		begin
			nvBits.hwProtectEnable <= frame.byte1[ST_HW_EN];
			nvBits.blockProtectHi  <= frame.byte1[ST_BP_HI];
			nvBits.blockProtectLo  <= frame.byte1[ST_BP_LO];
		end
	end

	assign nvStore = nvBits;

	// Internal write cycle timer
	assign busyEnd = writeInProgress && (busyCount == BUSY_ONE);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busyCount       <= BUSY_ZERO;
			writeInProgress <= 1'b0;
		end
		else if (startWrite)
		begin
			busyCount       <= BUSY_LOAD;
			writeInProgress <= 1'b1;
		end
		else if (busyEnd)
		begin
			busyCount       <= BUSY_ZERO;
			writeInProgress <= 1'b0;
		end
		else if (writeInProgress)
			busyCount <= busyCount - BUSY_ONE;
	end

	// Write latch; completion of a write has priority over any command
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			writeLatch <= 1'b0;
		else if (busyEnd)
			writeLatch <= 1'b0;
		else if (cmdLatchSet)
			writeLatch <= 1'b1;
		else if (cmdLatchClr)
			writeLatch <= 1'b0;
	end

	// Write request towards the array programmer
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			writeReq <= '0;
		else
		begin
			writeReq.start <= startWrite;
			if (startWrite)
			begin
				writeReq.toStatus <= cmdStatusWr;
				writeReq.addr     <= frameAddr;
			end
		end
	end

	// Readable status image
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			statusByte <= STAT_RST;
		else
			statusByte <= makeStatus(nvBits, writeLatch, writeInProgress);
	end

endmodule

// file: eewp_chk.sv
// Assertions on the write-protect block ports
module eewp_chk
	import eewp_pkg::*;
#(
	parameter int WRITE_CYCLES = 20
)
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// Pins
	input wire logic       csN,
	input wire logic       wpN,
	input wire logic       serialOutOe,
	// Results
	input eewp_nv_s        nvRestore,
	input eewp_nv_s        nvStore,
	input wire logic [7:0] statusByte,
	input eewp_wreq_s      writeReq,
	input wire logic       hwProtectActive,
	input wire logic       standby
);
	logic [3:0]  up;
	logic [19:0] busyLen;
	logic        sawHigh;

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	// Edges since reset; the pin synchroniser holds its reset value early on
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			up <= 4'h0;
		else if (up != 4'hf)
			up <= up + 4'h1;

	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			busyLen <= 20'h0;
		else
			busyLen <= statusByte[ST_WIP] ? busyLen + 20'h1 : 20'h0;

	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
			sawHigh <= 1'b0;
		else if (csN)
			sawHigh <= 1'b1;

	function automatic logic guarded(input logic [13:0] a, input eewp_nv_s nv);
		case ({nv.blockProtectHi, nv.blockProtectLo})
			BP_QUARTER: return a >= QUARTER_BASE;
			BP_HALF:    return a >= HALF_BASE;
			BP_ALL:     return 1'b1;
			default:    return 1'b0;
		endcase
	endfunction

	sequence s_busy_soon;
		##[0:2] statusByte[ST_WIP];
	endsequence

	sequence s_deselected;
		csN [*6];
	endsequence

	a_nv_restore: assert property (up == 4'h1 |-> nvStore == nvRestore)
		else $error("nonvolatile bits not restored");
	a_latch_power: assert property (up == 4'h2 |-> !statusByte[ST_LATCH] && statusByte[6:4] == 3'h0)
		else $error("status wrong after reset");
	a_hw_off: assert property (up > 4'h3 && ($past(wpN, 2) && $past(wpN, 3) || !nvStore.hwProtectEnable)
		|-> !hwProtectActive)
		else $error("hardware protect active while off");
	a_hw_on: assert property (up > 4'h3 && !$past(wpN, 2) && !$past(wpN, 3) && nvStore.hwProtectEnable
		|-> hwProtectActive)
		else $error("hardware protect not active");
	a_start_latch: assert property (writeReq.start |-> statusByte[ST_LATCH] && !$past(statusByte[ST_WIP], 2))
		else $error("write started without latch or while busy");
	a_start_unguard: assert property (writeReq.start && !writeReq.toStatus |-> !guarded(writeReq.addr, nvStore))
		else $error("write started in guarded range");
	a_status_hw: assert property (writeReq.start && writeReq.toStatus |-> !$past(hwProtectActive))
		else $error("status write under hardware protect");
	a_start_busy: assert property (writeReq.start |-> s_busy_soon)
		else $error("busy bit not raised");
	a_busy_len: assert property ($fell(statusByte[ST_WIP])
		|-> busyLen >= WRITE_CYCLES - 2 && busyLen <= WRITE_CYCLES + 2)
		else $error("write cycle length wrong");
	a_latch_drop: assert property ($fell(statusByte[ST_WIP]) |-> !statusByte[ST_LATCH])
		else $error("latch not cleared at write end");
	a_idle_standby: assert property (s_deselected |-> standby)
		else $error("not in standby while deselected");
	a_no_early: assert property (!sawHigh |-> standby)
		else $error("active without falling select");
	a_float_idle: assert property (csN && $past(csN) |-> !serialOutOe)
		else $error("output driven while deselected");
endmodule

bind eewp_write_protect eewp_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_eewp_chk (.ref_clk(ref_clk), .nrst(nrst),
	.csN(csN), .wpN(wpN), .serialOutOe(serialOutOe), .nvRestore(nvRestore), .nvStore(nvStore),
	.statusByte(statusByte), .writeReq(writeReq), .hwProtectActive(hwProtectActive), .standby(standby));

// file: eewp_host.sv
// Host serial controller model that frames instructions for the block
module eewp_host
(
	// Link pins driven by the host
	output logic      spiClk,
	output logic      csN,
	output logic      serialIn,
	// Read-back pins
	input  wire logic serialOut,
	input  wire logic serialOutOe
);
	timeunit 1ns;
	timeprecision 1ps;

	// Select starts low so a select present at power-up can be tried
	initial
	begin
		spiClk = 1'b0;
		csN = 1'b0;
		serialIn = 1'b0;
	end

	// Clock runs only inside the frame; bits after the eighth are read back
	task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rd);
		rd = 8'h00;
		#3;
		csN = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			serialIn = d[i];
			#6;
			spiClk = 1'b1;
			if (i < n - 8)
				rd = {rd[6:0], serialOutOe === 1'b1 ? serialOut : 1'bx};
			#6;
			spiClk = 1'b0;
		end
		// Data line no longer holds the last bit once released
		serialIn = ~serialIn;
		#6;
		csN = 1'b1;
	endtask
endmodule

// file: testbench.sv
// Self-checking bench for the write-protect block
module testbench;
	import eewp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WC = 60;
	logic             ref_clk, nrst, wpN, spiClk, csN, serialIn, serialOut, serialOutOe, hwProtectActive, standby;
	logic [7:0]       statusByte, rd;
	eewp_nv_s         nvRestore, nvStore;
	eewp_wreq_s       writeReq, lastReq;
	int               fails, checks, starts, s0;
	logic [15:0]      lim [4] = '{16'h4000, 16'h3000, 16'h2000, 16'h0000};
	logic [13:0]      adr [4] = '{14'h1fff, 14'h2000, 14'h2fff, 14'h3000};

	eewp_write_protect #(.WRITE_CYCLES(WC)) u_eewp_write_protect (.ref_clk(ref_clk), .nrst(nrst), .spiClk(spiClk),
		.csN(csN), .serialIn(serialIn), .serialOut(serialOut), .serialOutOe(serialOutOe), .wpN(wpN),
		.nvRestore(nvRestore), .nvStore(nvStore), .statusByte(statusByte), .writeReq(writeReq),
		.hwProtectActive(hwProtectActive), .standby(standby));
	eewp_host u_eewp_host (.spiClk(spiClk), .csN(csN), .serialIn(serialIn), .serialOut(serialOut),
		.serialOutOe(serialOutOe));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
		if (writeReq.start === 1'b1)
		begin
			starts++;
			lastReq = writeReq;
		end

	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Frame, then decode latency and the deselect gap
	task automatic frame(input logic [31:0] d, input int n);
		u_eewp_host.xfer(d, n, rd);
		cyc(8);
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		cmp("busy", 16'h1, 16'(statusByte[ST_WIP]));
		while (statusByte[ST_WIP] !== 1'b0 && n < WC + 20)
		begin
			cyc(1);
			n++;
		end
		if (n >= WC + 20)
		begin
			fails++;
			print_verdict();
		end
		cmp("latch after write", 16'h0, 16'(statusByte[ST_LATCH]));
	endtask

	// Write attempt after setting the latch; outcome judged by the start count
	task automatic arr(input logic [13:0] a, input logic ok);
		frame(32'h06, 8);
		s0 = starts;
		frame({8'h02, 2'b00, a, 8'h5a}, 32);
		cmp("array start", 16'(ok), 16'(starts - s0));
		if (ok)
			wait_done();
		else
			cmp("latch kept", 16'h1, 16'(statusByte[ST_LATCH]));
	endtask

	task automatic sw(input logic [7:0] v, input logic ok);
		frame(32'h06, 8);
		s0 = starts;
		frame({8'h01, v}, 16);
		cmp("status start", 16'(ok), 16'(starts - s0));
		if (ok)
			wait_done();
	endtask

	initial
	begin
		nrst = 1'b0;
		wpN = 1'b1;
		nvRestore = 3'b101;
		cyc(20);
		nrst <= 1'b1;
		cyc(6);
		cmp("standby", 16'h1, 16'(standby));
		cmp("power status", 16'h84, 16'(statusByte));
		cmp("output enable", 16'h0, 16'(serialOutOe));
		u_eewp_host.csN = 1'b1;
		cyc(6);
		frame(32'h02000011, 32);
		cmp("no latch write", 16'h0, 16'(starts));
		frame(32'h03, 7);
		frame(32'h0c, 9);
		cmp("miscounted set", 16'h0, 16'(statusByte[ST_LATCH]));
		frame(32'h06, 8);
		frame(32'h04, 8);
		u_eewp_host.xfer(32'h0500, 16, rd);
		cmp("status read", 16'h84, 16'(rd));
		cyc(8);
		wpN <= 1'b0;
		cyc(4);
		cmp("hw protect", 16'h1, 16'(hwProtectActive));
		sw(8'h8c, 1'b0);
		frame(32'h06, 8);
		s0 = starts;
		frame(32'h02010077, 32);
		frame(32'h02020077, 32);
		u_eewp_host.xfer(32'h0500, 16, rd);
		cmp("busy read", 16'h1, 16'(rd[ST_WIP]));
		cmp("busy refused", 16'h1, 16'(starts - s0));
		cmp("kept addr", 16'h0100, 16'(lastReq.addr));
		cyc(8);
		wait_done();
		wpN <= 1'b1;
		sw(8'hfc, 1'b1);
		cmp("nv bits", 16'h7, 16'(nvStore));
		for (int b = 0; b < 4; b++)
		begin
			sw({4'h0, 2'(b), 2'b00}, 1'b1);
			wpN <= 1'b0;
			cmp("bp bits", 16'(b), 16'(nvStore));
			for (int k = 0; k < 4; k++)
				arr(adr[k], 16'(adr[k]) < lim[b]);
		end
		cmp("hw off", 16'h0, 16'(hwProtectActive));
		print_verdict();
	end
endmodule
